// *** hdl/dpm_cts_timer.sv ***
`timescale 1ns/100ps
module dpm_cts_timer (
   input wire logic clk_i,
   input wire logic rst_n_i,
   dpm_line_if.timer line
);
   import dpm_pkg::*;

   logic [DLY_W:0] cnt;
   logic [DLY_W:0] next_cnt;
   logic cts;
   logic run;
   logic wait_done;
   logic step;

   // One extra tick absorbs the unknown phase of the free tick
   assign run = line.rts & line.arm;
   assign wait_done = cnt > {1'b0, line.dly}; // R14 R17
   assign step = line.tick & ~wait_done; // R20
   assign next_cnt = !run ? CNT_RST : (step ? cnt + 1'b1 : cnt); // R20 R21

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= CNT_RST;
         cts <= 1'b0;
      end else begin
         cnt <= next_cnt;
         cts <= run & wait_done; // R14 R21
      end
   end

   assign line.cts = cts;

   cts_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !line.rts |=> !cts) // R21
      else $error("clear-to-send held after request dropped");

   cts_min_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(cts) |-> $past(cnt) > {1'b0, $past(line.dly)}) // R14
      else $error("clear-to-send before the delay elapsed");

   cnt_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      run && line.tick && !wait_done && $stable(line.rts)
      |=> cnt == $past(cnt) + 1'b1 || !line.arm) // R20
      else $error("delay counter missed a tick");
endmodule : dpm_cts_timer

// *** hdl/dpm_line_if.sv ***
`timescale 1ns/100ps
interface dpm_line_if;
   import dpm_pkg::*;
   logic rts;
   logic tick;
   logic arm;
   logic [DLY_W-1:0] dly;
   logic cts;
   modport ctl (output rts, output tick, output arm, output dly,
                input cts);
   modport timer (input rts, input tick, input arm, input dly,
                  output cts);
endinterface : dpm_line_if

// *** hdl/dpm_pkg.sv ***
package dpm_pkg;
   localparam int NUM_LINES = 8;
   localparam int NUM_TARGETS = 10;
   localparam int TGT_W = 4;
   localparam logic [TGT_W-1:0] TGT_A = 4'h0;
   localparam logic [TGT_W-1:0] TGT_B = 4'h1;
   localparam logic [TGT_W-1:0] TGT_PORT0 = 4'h2;
   localparam int DLY_MS_W = 11;
   localparam int DLY_W = 7;
   localparam int DLY_MAX_MS = 1250;
   localparam int DLY_STEP_MS = 10;
   localparam int DLY_STEPS = DLY_MAX_MS / DLY_STEP_MS;
   localparam logic [DLY_W-1:0] DLY_RST = 7'h00;
   localparam logic [DLY_W:0] CNT_RST = 8'h00;
   localparam int CLK_MHZ = 250;
   localparam int TICK_MS = DLY_STEP_MS;
   localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;

   typedef enum logic [1:0] {
      DPM_TWO_PORT = 2'b00,
      DPM_TWO_MUX = 2'b01,
      DPM_EIGHT_IND = 2'b10,
      DPM_EIGHT_SHARED = 2'b11
   } dpm_unit_type;

   localparam dpm_unit_type UNIT_RST = DPM_TWO_PORT;

   typedef enum logic [2:0] {
      FLD_UNIT = 3'b000,
      FLD_MODE = 3'b001,
      FLD_GENDER = 3'b010,
      FLD_DUPLEX = 3'b011,
      FLD_DELAY = 3'b100,
      FLD_BRIDGE = 3'b101,
      FLD_TRANSP = 3'b110
   } dpm_field_type;

   typedef enum logic [1:0] {
      BR_NONE = 2'b00,
      BR_MASTER = 2'b01,
      BR_SLAVE = 2'b10
   } dpm_bridge_type;

   typedef struct packed {
      logic async;
      logic dte;
      logic shared_path_duplex;
      dpm_bridge_type bridge;
      logic transp;
      logic [DLY_W-1:0] dly;
   } dpm_circ_type;

   localparam dpm_circ_type CIRC_RST = '{
      async: 1'b0,
      dte: 1'b0,
      shared_path_duplex: 1'b0,
      bridge: BR_NONE,
      transp: 1'b0,
      dly: DLY_RST
   };
endpackage : dpm_pkg

// *** hdl/dpm_top.sv ***
`timescale 1ns/100ps
// Summary of operation
// R01: Two-port unit maps port A/B to circuits.
// R02: Unit type written on A, copied to B.
// R03: Per-circuit async/sync mode, resets synchronous.
// R04: Async frames characters; sync streams with clocks.
// R05: Async mode forbids transparent rate adaption.
// R06: Multiplexing variants fix aggregate sync, branch async.
// R07: Gender selects driven wire, defaults communications-side.
// R08: Terminal side sends transmit, other side receive.
// R09: Half duplex: one path, no simultaneous sending.
// R10: Full duplex default, both directions simultaneously.
// R11: Full duplex refuses delay setting changes.
// R12: Multidrop bridge forces duplex method automatically.
// R13: Sender raises request, waits for clear.
// R14: Clear-to-send only after configured delay.
// R15: Delay writable in half duplex or slave.
// R16: Delay 0 to 1250 ms, 10 ms steps.
// R17: Delay overshoot at most 20 ms.
// R18: Eight-port per-port variant: independent port settings.
// R19: Other eight-port variant: circuit B for all.
// R20: Ten-millisecond tick counter times the delay.
// R21: Clear drops one clock after request drops; cts_o drops three clocks after rts_i (two synchronizer stages).
module dpm_top #(
   parameter int TICK_CYCLES = dpm_pkg::TICK_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic cfg_wr_i,
   input wire logic [dpm_pkg::TGT_W-1:0] cfg_target_i,
   input wire dpm_pkg::dpm_field_type cfg_field_i,
   input wire logic [dpm_pkg::DLY_MS_W-1:0] cfg_data_i,
   input wire logic [dpm_pkg::NUM_LINES-1:0] rts_i,
   input wire logic [dpm_pkg::NUM_LINES-1:0] rx_busy_i,
   output logic cfg_ack_o,
   output logic cfg_reject_o,
   output dpm_pkg::dpm_unit_type unit_type_o,
   output logic [dpm_pkg::NUM_LINES-1:0] async_o,
   output logic [dpm_pkg::NUM_LINES-1:0] dte_o,
   output logic [dpm_pkg::NUM_LINES-1:0] shared_o,
   output logic [dpm_pkg::NUM_LINES-1:0] transp_o,
   output logic [dpm_pkg::NUM_LINES-1:0] cts_o,
   output logic [dpm_pkg::NUM_LINES-1:0] tx_en_o
);
   import dpm_pkg::*;

   localparam int TW = $clog2(TICK_CYCLES);

   if (TICK_CYCLES < 2) begin : g_chk
      $error("TICK_CYCLES must be at least 2");
   end

   function automatic logic [DLY_W:0] dly_decode(
      input logic [DLY_MS_W-1:0] ms
   );
      logic [DLY_W:0] r;
      r = '0;
      for (int k = 0; k <= DLY_STEPS; k++) begin
         if (ms == DLY_MS_W'(k * DLY_STEP_MS)) begin
            r = {1'b1, DLY_W'(k)};
         end
      end
      return r;
   endfunction : dly_decode

   function automatic logic is_mux(input dpm_unit_type u);
      return u == DPM_TWO_MUX || u == DPM_EIGHT_SHARED;
   endfunction : is_mux

   function automatic dpm_circ_type fix_cfg(
      input dpm_circ_type c,
      input dpm_unit_type u,
      input logic is_b
   );
      dpm_circ_type r;
      r = c;
      if (is_mux(u)) begin
         r.async = is_b; // R06
      end
      if (r.async) begin
         r.transp = 1'b0; // R05
      end
      if (r.bridge != BR_NONE) begin
         r.shared_path_duplex = 1'b1; // R12
      end
      return r;
   endfunction : fix_cfg

   function automatic dpm_circ_type apply_cfg(
      input dpm_circ_type c,
      input dpm_field_type f,
      input logic [DLY_MS_W-1:0] d,
      input logic [DLY_W-1:0] units
   );
      dpm_circ_type r;
      r = c;
      unique case (f)
         FLD_UNIT: begin
            r = c;
         end
         FLD_MODE: begin
            r.async = d[0]; // R03
            if (d[0]) begin
               r.transp = 1'b0; // R05
            end
         end
         FLD_GENDER: begin
            r.dte = d[0]; // R07
         end
         FLD_DUPLEX: begin
            r.shared_path_duplex = d[0];
         end
         FLD_DELAY: begin
            r.dly = units; // R16
         end
         FLD_BRIDGE: begin
            r.bridge = dpm_bridge_type'(d[1:0]);
            if (d[1:0] != BR_NONE) begin
               r.shared_path_duplex = 1'b1; // R12
            end
         end
         FLD_TRANSP: begin
            r.transp = d[0];
         end
         default: begin
            r = c;
         end
      endcase
      return r;
   endfunction : apply_cfg

   logic rst_s1;
   logic rst_n;
   logic [NUM_LINES-1:0] rts_s1;
   logic [NUM_LINES-1:0] rts_s2;
   logic [NUM_LINES-1:0] busy_s1;
   logic [NUM_LINES-1:0] busy_s2;
   logic [TW-1:0] tick_cnt;
   logic tick;
   logic tick_wrap;

   dpm_unit_type unit_a;
   dpm_unit_type unit_b;
   dpm_circ_type [NUM_TARGETS-1:0] recs;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rts_s1 <= '0;
         rts_s2 <= '0;
         busy_s1 <= '0;
         busy_s2 <= '0;
      end else begin
         rts_s1 <= rts_i;
         rts_s2 <= rts_s1;
         busy_s1 <= rx_busy_i;
         busy_s2 <= busy_s1;
      end
   end

   assign tick_wrap = tick_cnt == TW'(TICK_CYCLES - 1);

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1; // R20
         tick <= tick_wrap;
      end
   end

   // Write decode and acceptance checks
   logic tgt_ok;
   logic is_port;
   logic mode_fixed;
   logic dly_ok;
   logic accept;
   logic [DLY_W:0] dly_dec;
   dpm_circ_type cur;
   dpm_circ_type cur_eff;
   dpm_circ_type next_rec;

   assign is_port = cfg_target_i >= TGT_PORT0;
   assign tgt_ok = cfg_target_i < TGT_W'(NUM_TARGETS)
                   && (!is_port || unit_a == DPM_EIGHT_IND); // R18
   assign cur = tgt_ok ? recs[cfg_target_i] : CIRC_RST;
   assign cur_eff = fix_cfg(cur, unit_a, cfg_target_i == TGT_B);
   assign mode_fixed = is_mux(unit_a) && !is_port; // R06
   assign dly_dec = dly_decode(cfg_data_i); // R16
   assign dly_ok = dly_dec[DLY_W]
                   && (cur_eff.shared_path_duplex
                       || cur_eff.bridge == BR_SLAVE); // R11 R15

   always_comb begin
      accept = 1'b0;
      unique case (cfg_field_i)
         FLD_UNIT: accept = cfg_target_i == TGT_A; // R02
         FLD_MODE: accept = tgt_ok && !mode_fixed; // R06
         FLD_GENDER: accept = tgt_ok;
         FLD_DUPLEX: accept = tgt_ok && cur_eff.bridge == BR_NONE; // R12
         FLD_DELAY: accept = tgt_ok && dly_ok; // R11 R15 R16
         FLD_BRIDGE: accept = tgt_ok && cfg_data_i[1:0] != 2'b11;
         FLD_TRANSP: accept = tgt_ok
                              && !(cur_eff.async && cfg_data_i[0]); // R05
         default: accept = 1'b0;
      endcase
   end

   assign next_rec = apply_cfg(cur, cfg_field_i, cfg_data_i,
                               dly_dec[DLY_W-1:0]);

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         recs <= {NUM_TARGETS{CIRC_RST}}; // R03 R07 R10 R16
         unit_a <= UNIT_RST;
         unit_b <= UNIT_RST;
         cfg_ack_o <= 1'b0;
         cfg_reject_o <= 1'b0;
      end else begin
         cfg_ack_o <= cfg_wr_i & accept;
         cfg_reject_o <= cfg_wr_i & ~accept;
         if (cfg_wr_i && accept && cfg_field_i == FLD_UNIT) begin
            unit_a <= dpm_unit_type'(cfg_data_i[1:0]);
            unit_b <= dpm_unit_type'(cfg_data_i[1:0]); // R02
         end else if (cfg_wr_i && accept) begin
            recs[cfg_target_i] <= next_rec;
         end
      end
   end

   assign unit_type_o = unit_a;

   // Per-line effective settings and handshake timers
   dpm_circ_type eff_a;
   dpm_circ_type eff_b;
   dpm_circ_type [NUM_LINES-1:0] line_cfg;
   logic [NUM_LINES-1:0] line_use;

   assign eff_a = fix_cfg(recs[TGT_A], unit_a, 1'b0);
   assign eff_b = fix_cfg(recs[TGT_B], unit_a, 1'b1);

   for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
      dpm_line_if lif ();
      dpm_circ_type port_cfg;

      assign port_cfg = fix_cfg(recs[g + 2], unit_a, 1'b0); // R18
      assign line_use[g] = unit_a == DPM_EIGHT_IND
                           || unit_a == DPM_EIGHT_SHARED || g < 2;
      assign line_cfg[g] = unit_a == DPM_EIGHT_IND ? port_cfg // R18
                         : (unit_a == DPM_EIGHT_SHARED || g == 1)
                           ? eff_b : eff_a; // R01 R19

      assign lif.rts = rts_s2[g]; // R13
      assign lif.tick = tick;
      assign lif.arm = line_use[g] & ~line_cfg[g].dte; // R14
      assign lif.dly = line_cfg[g].dly;
      assign cts_o[g] = lif.cts;

      dpm_cts_timer u_timer (
         .clk_i(sys_clk_i),
         .rst_n_i(rst_n),
         .line(lif)
      );

      always_ff @(posedge sys_clk_i or negedge rst_n) begin
         if (!rst_n) begin
            async_o[g] <= 1'b0;
            dte_o[g] <= 1'b0;
            shared_o[g] <= 1'b0;
            transp_o[g] <= 1'b0;
            tx_en_o[g] <= 1'b0;
         end else begin
            async_o[g] <= line_use[g] & line_cfg[g].async; // R04
            dte_o[g] <= line_use[g] & line_cfg[g].dte; // R07 R08
            shared_o[g] <= line_use[g] & line_cfg[g].shared_path_duplex;
            transp_o[g] <= line_use[g] & line_cfg[g].transp;
            tx_en_o[g] <= line_use[g]
                          & (~line_cfg[g].shared_path_duplex
                             | ~busy_s2[g]); // R09 R10
         end
      end
   end

   sequence delay_wr_s;
      cfg_wr_i && cfg_field_i == FLD_DELAY;
   endsequence

   sequence mux_held_s;
      unit_a == DPM_TWO_MUX ##1 unit_a == DPM_TWO_MUX;
   endsequence

   dly_full_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      delay_wr_s and (!cur_eff.shared_path_duplex
                      && cur_eff.bridge != BR_SLAVE)
      |=> cfg_reject_o && $stable(recs)) // R11
      else $error("delay accepted in full duplex");

   dly_range_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      delay_wr_s and (cfg_data_i > DLY_MS_W'(DLY_MAX_MS))
      |=> cfg_reject_o && !cfg_ack_o) // R16
      else $error("delay outside range accepted");

   unit_copy_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      unit_b == unit_a) // R02
      else $error("unit type not copied to circuit B");

   mux_fixed_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      mux_held_s |-> !async_o[0] && async_o[1]) // R06
      else $error("multiplexing variant mode not fixed");

   bridge_half_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      cfg_wr_i && accept && cfg_field_i == FLD_BRIDGE
      && cfg_data_i[1:0] != 2'b00
      |=> recs[$past(cfg_target_i)].shared_path_duplex) // R12
      else $error("bridge did not force duplex method");

   transp_async_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      cfg_wr_i && cfg_field_i == FLD_TRANSP && cfg_data_i[0]
      && cur_eff.async |=> cfg_reject_o ##1 $stable(transp_o)) // R05
      else $error("transparent accepted in async mode");

   rst_default_a: assert property (@(posedge sys_clk_i)
      $rose(rst_n) |-> recs == {NUM_TARGETS{CIRC_RST}}
      && !cts_o[0] && !tx_en_o[0]) // R03 R07 R10
      else $error("settings not at reset defaults");
endmodule : dpm_top

// *** verification/dpm_dte_model.sv ***
`timescale 1ns/100ps
// Attached data equipment on each device line: raises the request and
// waits for clear before sending, and flags remote traffic.
module dpm_dte_model (
   input wire logic sys_clk_i,
   input wire logic [dpm_pkg::NUM_LINES-1:0] cts_i,
   output logic [dpm_pkg::NUM_LINES-1:0] rts_o,
   output logic [dpm_pkg::NUM_LINES-1:0] rx_busy_o
);
   initial begin
      rts_o = '0;
      rx_busy_o = '0;
   end

   // Data is withheld until clear returns or the limit runs out
   task automatic send(input int ln, input int lim, output int lat);
      lat = 0;
      @(posedge sys_clk_i);
      rts_o[ln] <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         #1;
         lat++;
      end while (cts_i[ln] !== 1'b1 && lat < lim);
   endtask : send

   task automatic drop(input int ln, output int lat);
      lat = 0;
      @(posedge sys_clk_i);
      rts_o[ln] <= 1'b0;
      do begin
         @(posedge sys_clk_i);
         #1;
         lat++;
      end while (cts_i[ln] !== 1'b0 && lat < 16);
   endtask : drop

   // Remote traffic is only flagged while the request is down
   task automatic busy(input int ln, input logic b);
      @(posedge sys_clk_i);
      rx_busy_o[ln] <= b & ~rts_o[ln];
   endtask : busy
endmodule : dpm_dte_model

// *** verification/dpm_top_tb_top.sv ***
`timescale 1ns/100ps
module dpm_top_tb_top;
   import dpm_pkg::*;
   localparam int TK = 20;
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic cfg_wr_i = 1'b0;
   logic [TGT_W-1:0] cfg_target_i = '0;
   dpm_field_type cfg_field_i = FLD_UNIT;
   logic [DLY_MS_W-1:0] cfg_data_i = '0;
   logic [NUM_LINES-1:0] rts_i, rx_busy_i, async_o, dte_o;
   logic [NUM_LINES-1:0] shared_o, transp_o, cts_o, tx_en_o;
   logic cfg_ack_o, cfg_reject_o;
   dpm_unit_type unit_type_o;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int lat;

   always #2 sys_clk_i = ~sys_clk_i;

   dpm_top #(.TICK_CYCLES(TK)) dut_u (.sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i), .cfg_wr_i(cfg_wr_i), .cfg_target_i(cfg_target_i),
      .cfg_field_i(cfg_field_i), .cfg_data_i(cfg_data_i), .rts_i(rts_i),
      .rx_busy_i(rx_busy_i), .cfg_ack_o(cfg_ack_o),
      .cfg_reject_o(cfg_reject_o), .unit_type_o(unit_type_o),
      .async_o(async_o), .dte_o(dte_o), .shared_o(shared_o),
      .transp_o(transp_o), .cts_o(cts_o), .tx_en_o(tx_en_o));

   dpm_dte_model dte_u (.sys_clk_i(sys_clk_i), .cts_i(cts_o),
      .rts_o(rts_i), .rx_busy_o(rx_busy_i));

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out

   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic rng(input int v, input int lo, input int hi);
      cmp_count++;
      if (v < lo || v > hi) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
      end
   endtask : rng

   // One write; ok=1 expects acceptance, ok=0 a refusal
   task automatic cfg(input logic [3:0] t, input dpm_field_type f,
                      input logic [10:0] d, input logic ok);
      @(posedge sys_clk_i);
      cfg_wr_i <= 1'b1;
      cfg_target_i <= t;
      cfg_field_i <= f;
      cfg_data_i <= d;
      @(posedge sys_clk_i);
      cfg_wr_i <= 1'b0;
      #1;
      chk({14'h0000, cfg_ack_o, cfg_reject_o}, {14'h0000, ok, ~ok});
      @(posedge sys_clk_i);
      #1;
   endtask : cfg

   task automatic t_reset;
      chk(16'(unit_type_o), 16'h0000);
      chk(16'(async_o), 16'h0000);
      chk(16'(dte_o), 16'h0000);
      chk(16'(shared_o), 16'h0000);
      chk(16'(tx_en_o), 16'h0003);
      $display("test reset done");
   endtask : t_reset

   task automatic t_delay;
      cfg(TGT_A, FLD_DELAY, 11'd20, 1'b0);
      cfg(TGT_A, FLD_DUPLEX, 11'd1, 1'b1);
      chk(16'(shared_o), 16'h0001);
      cfg(TGT_A, FLD_DELAY, 11'd25, 1'b0);
      cfg(TGT_A, FLD_DELAY, 11'd1260, 1'b0);
      cfg(TGT_A, FLD_DELAY, 11'd1250, 1'b1);
      cfg(TGT_A, FLD_DELAY, 11'd20, 1'b1);
      $display("test delay settings done");
   endtask : t_delay

   task automatic t_cts;
      dte_u.send(0, 4 * TK, lat);
      rng(lat, 2 * TK, 3 * TK + 8);
      dte_u.drop(0, lat);
      rng(lat, 1, 4);
      dte_u.send(0, 4 * TK, lat);
      rng(lat, 2 * TK, 3 * TK + 8);
      dte_u.drop(0, lat);
      dte_u.send(1, 2 * TK, lat);
      rng(lat, 1, TK + 8);
      dte_u.drop(1, lat);
      rng(lat, 1, 4);
      dte_u.busy(0, 1'b1);
      dte_u.busy(1, 1'b1);
      repeat (5) @(posedge sys_clk_i);
      #1;
      chk(16'(tx_en_o), 16'h0002);
      dte_u.busy(0, 1'b0);
      dte_u.busy(1, 1'b0);
      repeat (5) @(posedge sys_clk_i);
      #1;
      chk(16'(tx_en_o), 16'h0003);
      $display("test handshake done");
   endtask : t_cts

   task automatic t_gender;
      cfg(TGT_B, FLD_GENDER, 11'd1, 1'b1);
      chk(16'(dte_o), 16'h0002);
      dte_u.send(1, 2 * TK, lat);
      chk(16'(cts_o), 16'h0000);
      dte_u.drop(1, lat);
      cfg(TGT_B, FLD_GENDER, 11'd0, 1'b1);
      cfg(TGT_B, FLD_BRIDGE, 11'd1, 1'b1);
      chk(16'(shared_o), 16'h0003);
      cfg(TGT_B, FLD_DUPLEX, 11'd0, 1'b0);
      cfg(TGT_B, FLD_BRIDGE, 11'd3, 1'b0);
      cfg(TGT_B, FLD_BRIDGE, 11'h002, 1'b1);
      chk(16'(shared_o), 16'h0003);
      cfg(TGT_B, FLD_DELAY, 11'h01E, 1'b1);
      cfg(TGT_B, FLD_DELAY, 11'h01F, 1'b0);
      $display("test gender and bridge done");
   endtask : t_gender

   task automatic t_modes;
      cfg(TGT_A, FLD_MODE, 11'd1, 1'b1);
      chk(16'(async_o), 16'h0001);
      cfg(TGT_A, FLD_TRANSP, 11'd1, 1'b0);
      cfg(TGT_A, FLD_MODE, 11'd0, 1'b1);
      cfg(TGT_A, FLD_TRANSP, 11'd1, 1'b1);
      chk(16'(transp_o), 16'h0001);
      cfg(TGT_A, dpm_field_type'(3'h7), 11'h000, 1'b0);
      cfg(TGT_PORT0, FLD_MODE, 11'd1, 1'b0);
      cfg(TGT_B, FLD_UNIT, 11'd1, 1'b0);
      cfg(TGT_A, FLD_UNIT, 11'd1, 1'b1);
      chk(16'(unit_type_o), 16'h0001);
      chk(16'(async_o), 16'h0002);
      cfg(TGT_A, FLD_MODE, 11'd1, 1'b0);
      cfg(TGT_B, FLD_TRANSP, 11'd1, 1'b0);
      $display("test modes done");
   endtask : t_modes

   task automatic t_eight;
      cfg(TGT_A, FLD_UNIT, 11'd2, 1'b1);
      cfg(TGT_PORT0 + 4'h3, FLD_GENDER, 11'd1, 1'b1);
      chk(16'(dte_o), 16'h0008);
      cfg(4'hA, FLD_GENDER, 11'd1, 1'b0);
      cfg(TGT_A, FLD_UNIT, 11'd3, 1'b1);
      cfg(TGT_B, FLD_GENDER, 11'd1, 1'b1);
      chk(16'(dte_o), 16'h00FF);
      $display("test eight-port done");
   endtask : t_eight

   initial begin
      repeat (4) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      #1;
      t_reset();
      t_delay();
      t_cts();
      t_gender();
      t_modes();
      t_eight();
      close_out();
   end
endmodule : dpm_top_tb_top
